// file: core/vocmp_core.sv
// Notes on behaviour
// - Priority clear: player0/missile0, player1/missile1, ball/field, backdrop.
// - Priority bit set: field and ball above both player pairs.
// - Score bit: left field half uses player0 colour, right player1.
// - Reflect bit mirrors the right half of the field pattern.
// - Ball width 1, 2, 4 or 8 clocks from control bits 5:4.
// - Two objects active in the same clock form a collision.
// - Fifteen single-bit latches, one per object pair.
// - Each overlap read returns two latches on bits 7 and 6; ball/field returns one, on bit 7.
// - Writing the clear strobe resets every latch not hit in that clock, any data.
// - Four seven-bit colour registers: player0, player1, field, backdrop.
// - Upper four bits pick hue, next three pick brightness.
// - Missiles share their player's colour register.
// - Priority select drives a four-way seven-bit colour multiplexer.
// - Luminance and sync go to video, hue lines to phase shifter.
// - Chroma carries burst during horizontal blank, no phase during vertical blank, else the hue phase.
// - Hue 0 no colour, 1 burst phase, 2..15 growing delays.
// - Vertical sync bit 1 starts sync when set, ends when cleared.
// - Vertical blank: bit 1 blank, bit 6 latch enable, bit 7 dump.
// - Field is twenty bits from three registers, four clocks each.
// - Exactly one of four select lines is active each clock.
//
// Implementation choices: register access over APB and the register addresses.
module vocmp_core #(
    parameter int BALL_CNT_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire vocmp_pkg::vocmp_objects_t objects,
    input wire vocmp_pkg::vocmp_beam_t beam,
    output vocmp_pkg::vocmp_video_t video,
    output logic [3:0] select_lines,
    output logic vertical_sync,
    output logic vertical_blank,
    output logic input_latch_enable,
    output logic input_dump
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] vsync_ctl;
        logic [7:0] vertical_blank_control_ctl;
        logic [7:0] pattern_upper;
        logic [7:0] pattern_middle;
        logic [7:0] pattern_lower;
        logic [7:0] field_ctl;
        logic [3:0][6:0] colour;
        logic [15:0] overlap;
        logic [BALL_CNT_W-1:0] ball_cnt;
        logic ball_run;
        vocmp_pkg::vocmp_video_t video;
        logic [3:0] select;
    } vocmp_state_t;

    vocmp_state_t st_q;
    vocmp_state_t st_d;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic [5:0] idx;
    logic addr_ok;
    logic wr_en;
    logic rd_en;
    logic clear_hit;

    localparam int IDX_LSB = vocmp_pkg::IDX_LSB;

    assign idx = paddr[IDX_LSB+5:IDX_LSB];
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign clear_hit = wr_en && (idx == vocmp_pkg::IDX_OVERLAP_CLEAR);

    // Map check; low address bits and upper bits must be clean
    always_comb
    begin
        addr_ok = (paddr[IDX_LSB-1:0] == 2'h0)
            && (paddr[11:IDX_LSB+6] == 4'h0);
        if (idx <= vocmp_pkg::IDX_PLAYER_MISSILE)
            addr_ok = addr_ok && !pwrite;
        else if (idx >= vocmp_pkg::IDX_VERTICAL_SYNC
            && idx <= vocmp_pkg::IDX_OVERLAP_CLEAR)
            addr_ok = addr_ok && pwrite;
        else
            addr_ok = 1'b0;
    end

    assign pslverr = psel && penable && !addr_ok;

    // Read mux; only the overlap registers read back, bits 7 and 6
    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_en && addr_ok)
        begin
            prdata[vocmp_pkg::OVERLAP_HI] = st_q.overlap[{idx[2:0], 1'b1}];
            prdata[vocmp_pkg::OVERLAP_LO] = st_q.overlap[{idx[2:0], 1'b0}];
        end
    end

    // ------------------------------------------------------------
    // Playfield serialiser
    // ------------------------------------------------------------
    logic [19:0] pattern;
    logic right_half;
    logic [7:0] half_pos;
    logic [4:0] field_bit;
    logic field_on;

    // Twenty bits, upper nibble first, middle reversed order
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pattern[i] = st_q.pattern_upper[4+i];
        for (int i = 0; i < 8; i++)
            pattern[4+i] = st_q.pattern_middle[7-i];
        for (int i = 0; i < 8; i++)
            pattern[12+i] = st_q.pattern_lower[i];
    end

    assign right_half = beam.hpos >= vocmp_pkg::HALF_LINE;
    assign half_pos = right_half ? beam.hpos - vocmp_pkg::HALF_LINE
        : beam.hpos;

    // Each pattern bit stands for four colour clocks
    always_comb
    begin
        field_bit = half_pos[vocmp_pkg::FIELD_BIT_SHIFT+4:
            vocmp_pkg::FIELD_BIT_SHIFT];
        if (right_half && st_q.field_ctl[vocmp_pkg::CTRL_REFLECT])
            field_bit = vocmp_pkg::FIELD_BITS_LAST - field_bit;
        field_on = (field_bit <= vocmp_pkg::FIELD_BITS_LAST)
            && pattern[field_bit] && !beam.hblank;
    end

    // ------------------------------------------------------------
    // Ball stretcher
    // ------------------------------------------------------------
    logic [1:0] ball_code;
    logic [BALL_CNT_W-1:0] ball_len;
    logic ball_on;

    assign ball_code = st_q.field_ctl[vocmp_pkg::CTRL_BALL_HI:
        vocmp_pkg::CTRL_BALL_LO];
    // Extra clocks beyond the first; codes 00..11 give 1, 2, 4, 8
    assign ball_len = BALL_CNT_W'((1 << ball_code) - 1);
    assign ball_on = objects.ball_start || st_q.ball_run;

    // ------------------------------------------------------------
    // Collision and priority
    // ------------------------------------------------------------
    logic p0;
    logic p1;
    logic m0;
    logic m1;
    logic bl;
    logic pf;
    logic [15:0] hits;
    vocmp_pkg::vocmp_sel_t sel;

    assign p0 = objects.player_zero;
    assign p1 = objects.player_one;
    assign m0 = objects.missile_zero;
    assign m1 = objects.missile_one;
    assign bl = ball_on;
    assign pf = field_on;

    // Pair order follows the eight overlap read registers
    always_comb
    begin
        hits = 16'h0000;
        hits[1] = m0 && p1;
        hits[0] = m0 && p0;
        hits[3] = m1 && p0;
        hits[2] = m1 && p1;
        hits[5] = p0 && pf;
        hits[4] = p0 && bl;
        hits[7] = p1 && pf;
        hits[6] = p1 && bl;
        hits[9] = m0 && pf;
        hits[8] = m0 && bl;
        hits[11] = m1 && pf;
        hits[10] = m1 && bl;
        hits[13] = bl && pf;
        hits[15] = p0 && p1;
        hits[14] = m0 && m1;
    end

    // Priority encoder; missiles ride with their players
    always_comb
    begin
        sel = vocmp_pkg::SEL_BACKDROP;
        if (st_q.field_ctl[vocmp_pkg::CTRL_PRIORITY])
        begin
            if (pf || bl)
                sel = vocmp_pkg::SEL_FIELD;
            else if (p0 || m0)
                sel = vocmp_pkg::SEL_PLAYER0;
            else if (p1 || m1)
                sel = vocmp_pkg::SEL_PLAYER1;
        end
        else
        begin
            if (p0 || m0)
                sel = vocmp_pkg::SEL_PLAYER0;
            else if (p1 || m1)
                sel = vocmp_pkg::SEL_PLAYER1;
            else if (pf || bl)
                sel = vocmp_pkg::SEL_FIELD;
        end
    end

    // ------------------------------------------------------------
    // Colour multiplexer
    // ------------------------------------------------------------
    logic [6:0] pixel;
    logic [1:0] colour_idx;

    // Score mode recolours only the field pattern, not the ball
    always_comb
    begin
        colour_idx = 2'(sel);
        if (sel == vocmp_pkg::SEL_FIELD && pf && !bl
            && st_q.field_ctl[vocmp_pkg::CTRL_SCORE])
            colour_idx = right_half ? 2'(vocmp_pkg::SEL_PLAYER1)
                : 2'(vocmp_pkg::SEL_PLAYER0);
        pixel = st_q.colour[colour_idx];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic blanked;
    logic [3:0] hue_now;

    assign blanked = beam.hblank
        || st_q.vertical_blank_control_ctl[vocmp_pkg::VERTICAL_BLANK_CONTROL_BIT];
    assign hue_now = pixel[vocmp_pkg::COLOUR_HUE_HI-1:
        vocmp_pkg::COLOUR_HUE_LO-1];

    always_comb
    begin
        st_d = st_q;
        // Register writes
        if (wr_en && addr_ok)
        begin
            if (idx == vocmp_pkg::IDX_VERTICAL_SYNC)
                st_d.vsync_ctl = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_VERTICAL_BLANK)
                st_d.vertical_blank_control_ctl = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_PATTERN_UPPER)
                st_d.pattern_upper = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_PATTERN_MIDDLE)
                st_d.pattern_middle = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_PATTERN_LOWER)
                st_d.pattern_lower = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_FIELD_CONTROL)
                st_d.field_ctl = pwdata[7:0];
            else if (idx == vocmp_pkg::IDX_PLAYER0_COLOUR)
                st_d.colour[vocmp_pkg::SEL_PLAYER0] = pwdata[7:1];
            else if (idx == vocmp_pkg::IDX_PLAYER1_COLOUR)
                st_d.colour[vocmp_pkg::SEL_PLAYER1] = pwdata[7:1];
            else if (idx == vocmp_pkg::IDX_FIELD_COLOUR)
                st_d.colour[vocmp_pkg::SEL_FIELD] = pwdata[7:1];
            else if (idx == vocmp_pkg::IDX_BACKDROP_COLOUR)
                st_d.colour[vocmp_pkg::SEL_BACKDROP] = pwdata[7:1];
        end
        // Latches hold until cleared; a hit in the clear cycle wins
        if (clear_hit)
            st_d.overlap = 16'h0000;
        st_d.overlap = st_d.overlap | hits;
        // Ball run counter
        if (objects.ball_start)
        begin
            st_d.ball_cnt = ball_len;
            st_d.ball_run = ball_len != '0;
        end
        else if (st_q.ball_run)
        begin
            st_d.ball_cnt = st_q.ball_cnt - 1'b1;
            st_d.ball_run = st_q.ball_cnt > 1;
        end
        // Pixel outputs, registered
        st_d.video.blank = blanked;
        st_d.video.sync = beam.hsync
            || st_q.vsync_ctl[vocmp_pkg::VSYNC_BIT];
        st_d.video.luma = blanked ? 3'h0
            : pixel[vocmp_pkg::COLOUR_LUM_HI-1:
                vocmp_pkg::COLOUR_LUM_LO-1];
        st_d.video.hue = hue_now;
        // Burst on horizontal blank, else hue-selected phase, none for hue 0 or vertical blank
        if (beam.hblank)
        begin
            st_d.video.chroma_on = 1'b1;
            st_d.video.chroma_phase = vocmp_pkg::HUE_BURST;
        end
        else
        begin
            st_d.video.chroma_on = !blanked
                && hue_now != vocmp_pkg::HUE_NONE;
            st_d.video.chroma_phase = blanked ? vocmp_pkg::HUE_NONE
                : hue_now;
        end
        st_d.select = 4'h1 << sel;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q.vsync_ctl <= vocmp_pkg::RESET_BYTE;
            st_q.vertical_blank_control_ctl <= vocmp_pkg::RESET_BYTE;
            st_q.pattern_upper <= vocmp_pkg::RESET_BYTE;
            st_q.pattern_middle <= vocmp_pkg::RESET_BYTE;
            st_q.pattern_lower <= vocmp_pkg::RESET_BYTE;
            st_q.field_ctl <= vocmp_pkg::RESET_BYTE;
            st_q.colour <= {4{vocmp_pkg::RESET_COLOUR}};
            st_q.overlap <= 16'h0000;
            st_q.ball_cnt <= '0;
            st_q.ball_run <= 1'b0;
            st_q.video <= '0;
            st_q.select <= 4'h1;
        end
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Phase delay itself is analog; the code leaves on chroma_phase
    assign video = st_q.video;
    assign select_lines = st_q.select;
    assign vertical_sync = st_q.vsync_ctl[vocmp_pkg::VSYNC_BIT];
    assign vertical_blank = st_q.vertical_blank_control_ctl[vocmp_pkg::VERTICAL_BLANK_CONTROL_BIT];
    assign input_latch_enable =
        st_q.vertical_blank_control_ctl[vocmp_pkg::VERTICAL_BLANK_CONTROL_LATCH_BIT];
    assign input_dump = st_q.vertical_blank_control_ctl[vocmp_pkg::VERTICAL_BLANK_CONTROL_DUMP_BIT];

endmodule

// file: core/vocmp_pkg.sv
package vocmp_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_MISSILE0_OVERLAP = 6'h00;
    localparam logic [5:0] IDX_MISSILE1_OVERLAP = 6'h01;
    localparam logic [5:0] IDX_PLAYER0_OVERLAP = 6'h02;
    localparam logic [5:0] IDX_PLAYER1_OVERLAP = 6'h03;
    localparam logic [5:0] IDX_MISSILE0_FIELD = 6'h04;
    localparam logic [5:0] IDX_MISSILE1_FIELD = 6'h05;
    localparam logic [5:0] IDX_BALL_FIELD = 6'h06;
    localparam logic [5:0] IDX_PLAYER_MISSILE = 6'h07;
    localparam logic [5:0] IDX_VERTICAL_SYNC = 6'h10;
    localparam logic [5:0] IDX_VERTICAL_BLANK = 6'h11;
    localparam logic [5:0] IDX_PATTERN_UPPER = 6'h12;
    localparam logic [5:0] IDX_PATTERN_MIDDLE = 6'h13;
    localparam logic [5:0] IDX_PATTERN_LOWER = 6'h14;
    localparam logic [5:0] IDX_FIELD_CONTROL = 6'h15;
    localparam logic [5:0] IDX_PLAYER0_COLOUR = 6'h16;
    localparam logic [5:0] IDX_PLAYER1_COLOUR = 6'h17;
    localparam logic [5:0] IDX_FIELD_COLOUR = 6'h18;
    localparam logic [5:0] IDX_BACKDROP_COLOUR = 6'h19;
    localparam logic [5:0] IDX_OVERLAP_CLEAR = 6'h1A;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_REFLECT = 0;
    localparam int CTRL_SCORE = 1;
    localparam int CTRL_PRIORITY = 2;
    localparam int CTRL_BALL_LO = 4;
    localparam int CTRL_BALL_HI = 5;
    localparam int VSYNC_BIT = 1;
    localparam int VERTICAL_BLANK_CONTROL_BIT = 1;
    localparam int VERTICAL_BLANK_CONTROL_LATCH_BIT = 6;
    localparam int VERTICAL_BLANK_CONTROL_DUMP_BIT = 7;
    localparam int OVERLAP_HI = 7;
    localparam int OVERLAP_LO = 6;
    localparam int COLOUR_HUE_HI = 7;
    localparam int COLOUR_HUE_LO = 4;
    localparam int COLOUR_LUM_HI = 3;
    localparam int COLOUR_LUM_LO = 1;

    // ------------------------------------------------------------
    // Picture geometry and timing
    // ------------------------------------------------------------
    localparam logic [7:0] HALF_LINE = 8'h50;
    localparam logic [4:0] FIELD_BITS_LAST = 5'h13;
    localparam int FIELD_BIT_SHIFT = 2;
    localparam logic [3:0] HUE_NONE = 4'h0;
    localparam logic [3:0] HUE_BURST = 4'h1;
    localparam int PHASE_STEP_NS = 20;
    localparam int CLOCK_NS = 25;
    localparam int PHASE_STEP_CYCLES =
        (PHASE_STEP_NS / CLOCK_NS) < 1 ? 1 : PHASE_STEP_NS / CLOCK_NS;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [6:0] RESET_COLOUR = 7'h00;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SEL_BACKDROP,
        SEL_PLAYER0,
        SEL_PLAYER1,
        SEL_FIELD
    } vocmp_sel_t;

    // Serial outputs of the moveable objects, one bit each
    typedef struct packed {
        logic player_zero;
        logic player_one;
        logic missile_zero;
        logic missile_one;
        logic ball_start;
    } vocmp_objects_t;

    // Beam timing from the line and frame counters
    typedef struct packed {
        logic [7:0] hpos;
        logic hblank;
        logic hsync;
    } vocmp_beam_t;

    // Video towards the converter and the phase shifter
    typedef struct packed {
        logic [2:0] luma;
        logic sync;
        logic blank;
        logic [3:0] hue;
        logic chroma_on;
        logic [3:0] chroma_phase;
    } vocmp_video_t;

endpackage

// file: tb/vocmp_monitor.sv
// ----------------------------------------
// Port checker for the compositor
// ----------------------------------------
module vocmp_monitor #(
    parameter int BALL_CNT_W = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire vocmp_pkg::vocmp_objects_t objects,
    input wire vocmp_pkg::vocmp_beam_t beam,
    input wire vocmp_pkg::vocmp_video_t video,
    input wire logic [3:0] select_lines,
    input wire logic vertical_sync,
    input wire logic vertical_blank,
    input wire logic input_latch_enable,
    input wire logic input_dump
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wr;
    logic rd;
    logic clr;
    logic no_pm;
    logic pp_q;
    logic [7:0] ctrl_q;
    // Completed bus phases; players and missiles quiet
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign clr = wr && paddr[7:2] == vocmp_pkg::IDX_OVERLAP_CLEAR;
    assign no_pm = objects[4:1] == 4'h0;
    // Shadows; a hit in the clearing cycle still sets the latch
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 8'h00;
            pp_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr[7:2] == vocmp_pkg::IDX_FIELD_CONTROL)
                ctrl_q <= pwdata[7:0];
            pp_q <= (objects.player_zero && objects.player_one)
                || (pp_q && !clr);
        end
    end
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Eight-clock ball with nothing else moving
    sequence ball_eight;
        objects.ball_start && ctrl_q[5:4] == 2'h3 && no_pm ##1 no_pm [*7];
    endsequence
    AST_ONE_HOT: assert property ($onehot(select_lines))
        else $error("select lines not one-hot");
    AST_PAIR_ZERO: assert property ((objects.player_zero
        || objects.missile_zero) && !ctrl_q[2] |=> select_lines == 4'h2)
        else $error("player zero pair not in front");
    AST_PAIR_ONE: assert property ((objects.player_one
        || objects.missile_one) && !objects.player_zero
        && !objects.missile_zero && !ctrl_q[2] |=> select_lines == 4'h4)
        else $error("player one pair not in front");
    AST_FIELD_FIRST: assert property (objects.ball_start
        && ctrl_q[2] |=> select_lines == 4'h8)
        else $error("field priority ignored");
    AST_BALL_WIDTH: assert property (ball_eight |=> select_lines[3])
        else $error("ball shorter than eight clocks");
    AST_OVERLAP: assert property (rd && paddr[7:2] ==
        vocmp_pkg::IDX_PLAYER_MISSILE |-> prdata[7] == pp_q)
        else $error("player overlap latch wrong");
    AST_READ_BITS: assert property (rd |-> prdata[31:8] == 24'h0
        && prdata[5:0] == 6'h00)
        else $error("read data outside bits 7 and 6");
    AST_BURST: assert property (beam.hblank |=> video.luma == 3'h0
        && video.chroma_phase == vocmp_pkg::HUE_BURST)
        else $error("no burst in horizontal blank");
    AST_HSYNC: assert property (beam.hsync |=> video.sync)
        else $error("sync missing on video");
    AST_VSYNC: assert property (wr && paddr[7:2] ==
        vocmp_pkg::IDX_VERTICAL_SYNC |=> vertical_sync == $past(pwdata[1]))
        else $error("vertical sync bit not followed");
    AST_VERTICAL_BLANK_CONTROL: assert property (wr && paddr[7:2] ==
        vocmp_pkg::IDX_VERTICAL_BLANK |=> vertical_blank == $past(pwdata[1])
        && input_dump == $past(pwdata[7]))
        else $error("vertical blank bits not followed");
endmodule

bind vocmp_core vocmp_monitor #(.BALL_CNT_W(BALL_CNT_W)) i_mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .objects, .beam, .video, .select_lines,
    .vertical_sync, .vertical_blank, .input_latch_enable, .input_dump
);

// file: tb/vocmp_tv_model.sv
// ----------------------------------------
// Receiver stand-in on the video outputs
// ----------------------------------------
module vocmp_tv_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire vocmp_pkg::vocmp_video_t video,
    output logic [15:0] burst_cycles
);
    timeunit 1ns;
    timeprecision 100ps;
    // Counts reference cycles a set would lock its colour onto
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            burst_cycles <= 16'h0000;
        else if (video.chroma_phase == vocmp_pkg::HUE_BURST)
            burst_cycles <= burst_cycles + 16'h0001;
    end
endmodule

// file: tb/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] C_P0 = 8'h2E;
    localparam logic [7:0] C_P1 = 8'h4A;
    localparam logic [7:0] C_PF = 8'h86;
    localparam logic [7:0] C_BK = 8'hC2;
    localparam int LIMIT = 5000;
    typedef struct packed {
        logic [7:0] ctrl;
        logic [4:0] obj;
        logic [7:0] hpos;
        logic [7:0] col;
        logic [3:0] sel;
    } vocmp_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    vocmp_pkg::vocmp_objects_t objects = '0;
    vocmp_pkg::vocmp_beam_t beam = '0;
    vocmp_pkg::vocmp_video_t video;
    logic [3:0] select_lines;
    logic vertical_sync;
    logic vertical_blank;
    logic input_latch_enable;
    logic input_dump;
    logic [3:0] vctl;
    logic [15:0] burst_cycles;
    logic [15:0] b0;
    logic [31:0] rdata;
    logic err;
    int n_fail = 0;
    int total_checks = 0;
    int cycles = 0;
    int cnt;
    logic [7:0] hits [8] = '{8'hC0, 8'h00, 8'hC0, 8'hC0, 8'hC0, 8'h00,
        8'h80, 8'h80};
    // Field pattern has its first four bits lit: pixels 0..15
    vocmp_row_t rows [18] = '{
        '{8'h00, 5'h00, 8'h20, C_BK, 4'h1}, '{8'h00, 5'h10, 8'h20, C_P0, 4'h2},
        '{8'h00, 5'h04, 8'h20, C_P0, 4'h2}, '{8'h00, 5'h02, 8'h20, C_P1, 4'h4},
        '{8'h00, 5'h09, 8'h20, C_P1, 4'h4}, '{8'h00, 5'h19, 8'h20, C_P0, 4'h2},
        '{8'h00, 5'h01, 8'h20, C_PF, 4'h8}, '{8'h04, 5'h11, 8'h20, C_PF, 4'h8},
        '{8'h04, 5'h12, 8'h04, C_PF, 4'h8}, '{8'h00, 5'h10, 8'h04, C_P0, 4'h2},
        '{8'h00, 5'h00, 8'h0F, C_PF, 4'h8}, '{8'h00, 5'h00, 8'h10, C_BK, 4'h1},
        '{8'h00, 5'h00, 8'h54, C_PF, 4'h8}, '{8'h01, 5'h00, 8'h54, C_BK, 4'h1},
        '{8'h01, 5'h00, 8'h9F, C_PF, 4'h8}, '{8'h02, 5'h00, 8'h04, C_P0, 4'h0},
        '{8'h02, 5'h00, 8'h54, C_P1, 4'h0}, '{8'h02, 5'h01, 8'h20, C_PF, 4'h8}};
    assign vctl = {vertical_sync, vertical_blank, input_latch_enable,
        input_dump};
    vocmp_core i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .objects, .beam, .video, .select_lines,
        .vertical_sync, .vertical_blank, .input_latch_enable, .input_dump
    );
    vocmp_tv_model i_tv (.pclk, .presetn, .video, .burst_cycles);
    always #12.5 pclk = ~pclk;
    // Watchdog: a stuck wait must not run forever
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; no wait count assumed, the watchdog ends a hang
    task automatic apb(input logic wr, input logic [5:0] idx,
        input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {4'h0, idx, 2'h0};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, {24'h000000, d});
    endtask
    task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 32'h0000_0000);
        chk("prdata", {24'h000000, exp}, rdata);
    endtask
    // One pixel of objects; outputs settled one clock later
    task automatic pix(input logic [4:0] obj, input logic [7:0] hpos);
        @(posedge pclk);
        objects <= obj;
        beam <= {hpos, 2'h0};
        @(posedge pclk);
        objects <= '0;
        #1;
    endtask
    task automatic vchk(input logic [7:0] col);
        chk("video", 32'({col[3:1], col[7:4], col[7:4]}),
            32'({video.luma, video.hue, video.chroma_phase}));
    endtask
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        #1;
        chk("select", 32'h1, 32'(select_lines));
        chk("video", 32'h0, 32'(video));
        chk("vctl", 32'h0, 32'(vctl));
        @(posedge pclk);
        presetn <= 1'b1;
        $display("test reset done");
        wreg(vocmp_pkg::IDX_PLAYER0_COLOUR, C_P0);
        wreg(vocmp_pkg::IDX_PLAYER1_COLOUR, C_P1);
        wreg(vocmp_pkg::IDX_FIELD_COLOUR, C_PF);
        wreg(vocmp_pkg::IDX_BACKDROP_COLOUR, C_BK);
        wreg(vocmp_pkg::IDX_PATTERN_UPPER, 8'hF0);
        foreach (rows[i])
        begin
            wreg(vocmp_pkg::IDX_FIELD_CONTROL, rows[i].ctrl);
            pix(rows[i].obj, rows[i].hpos);
            if (rows[i].sel !== 4'h0)
                chk("select", 32'(rows[i].sel), 32'(select_lines));
            vchk(rows[i].col);
        end
        $display("test table done");
        for (int w = 0; w < 4; w++)
        begin
            wreg(vocmp_pkg::IDX_FIELD_CONTROL, 8'(w << 4));
            pix(5'h01, 8'h20);
            cnt = 0;
            repeat (12)
            begin
                if (select_lines === 4'h8)
                    cnt++;
                @(posedge pclk);
                #1;
            end
            chk("ball width", 32'(1 << w), 32'(cnt));
        end
        $display("test ball done");
        wreg(vocmp_pkg::IDX_FIELD_CONTROL, 8'h00);
        wreg(vocmp_pkg::IDX_OVERLAP_CLEAR, 8'h5A);
        pix(5'h1D, 8'h04);
        repeat (20) @(posedge pclk);
        for (int k = 0; k < 8; k++)
            rchk(6'(k), hits[k]);
        wreg(vocmp_pkg::IDX_OVERLAP_CLEAR, 8'h5A);
        for (int k = 0; k < 8; k++)
            rchk(6'(k), 8'h00);
        apb(1'b0, 6'h08, 32'h0000_0000);
        chk("slverr", 32'h1, 32'(err));
        chk("prdata", 32'h0, rdata);
        apb(1'b1, vocmp_pkg::IDX_PLAYER_MISSILE, 32'h0000_00C0);
        chk("slverr", 32'h1, 32'(err));
        rchk(vocmp_pkg::IDX_PLAYER_MISSILE, 8'h00);
        $display("test overlap done");
        wreg(vocmp_pkg::IDX_VERTICAL_SYNC, 8'h02);
        wreg(vocmp_pkg::IDX_VERTICAL_BLANK, 8'hC2);
        #1;
        chk("vctl", 32'hF, 32'(vctl));
        pix(5'h10, 8'h20);
        chk("luma", 32'h0, 32'(video.luma));
        chk("blank", 32'h1, 32'(video.blank));
        chk("sync", 32'h1, 32'(video.sync));
        wreg(vocmp_pkg::IDX_VERTICAL_SYNC, 8'hFD);
        wreg(vocmp_pkg::IDX_VERTICAL_BLANK, 8'h3D);
        #1;
        chk("vctl", 32'h0, 32'(vctl));
        $display("test vertical done");
        b0 = burst_cycles;
        @(posedge pclk);
        beam <= {8'h00, 2'h3};
        repeat (10) @(posedge pclk);
        beam <= {8'h20, 2'h0};
        @(posedge pclk);
        #1;
        chk("burst", 32'(b0 + 16'h000A), 32'(burst_cycles));
        $display("test blank done");
        results();
    end
endmodule
